// [logic/mfd_cfg.svh]
// Function
// RULE1: microinstruction is 32 bits, bit 31 MSB
// RULE2: fields mode, ALU, test, special, constant
// RULE3: mode picks addressing mode and format
// RULE4: bit 19 selects subformat in formats 1-2
// RULE5: ALU function, A, B, destination fields
// RULE6: shift fields direction, A/AQ, control, no dest
// RULE7: test field picks upper or lower instruction
// RULE8: format 1 alternate test select bit
// RULE9: format 1 constant or transform codes
// RULE10: format 2 same-page jump with special op
// RULE11: format 2 full address page jump
// RULE12: format 3 special op, N/K load
// RULE13: override flag suppresses special for transforms; the code suppresses only transform codes that match the value/mask pair
// RULE14: special requests memory and alternate codings
// RULE15: return uses return register, sequential counter
// RULE16: jump target pair, page by bit 19
// RULE17: decoded outputs combinational from current word
`ifndef MFD_CFG_SVH
`define MFD_CFG_SVH
`define MFD_UI_W        32
`define MFD_MODE_LSB    0
`define MFD_ALU_F_LSB   2
`define MFD_SRC_A_LSB   7
`define MFD_SRC_B_LSB   10
`define MFD_DEST_LSB    13
`define MFD_SH_RIGHT    7
`define MFD_SH_LEFT     8
`define MFD_SH_AQ       9
`define MFD_SH_CTL_LSB  11
`define MFD_TEST_LSB    16
`define MFD_SF_BIT      19
`define MFD_SPEC_LSB    20
`define MFD_CONST_LSB   24
`define MFD_TALT_BIT    24
`define MFD_CCODE_LSB   25
`define MFD_SHIFT_F_HI  3'h7
`define MFD_S_MEM_RD    4'h1
`define MFD_S_MEM_WR    4'h2
`define MFD_S_ALT_A     4'h3
`define MFD_S_ALT_B     4'h4
`define MFD_S_ALT_D     4'h5
`define MFD_OFS_CTRL    8'h00
`define MFD_OFS_XFORM   8'h04
`define MFD_OFS_NREG    8'h08
`define MFD_OFS_KREG    8'h0C
`define MFD_OFS_LASTUI  8'h10
`define MFD_OFS_STATUS  8'h14
`define MFD_OFS_EXECNT  8'h18
`define MFD_CTRL_OVR    0
`define MFD_XF_VAL_LSB  0
`define MFD_XF_MSK_LSB  8
`define MFD_RST_CTRL    1'h0
`define MFD_RST_XVAL    7'h00
`define MFD_RST_XMSK    7'h7F
`endif

// [logic/mfd_pkg.sv]
package mfd_pkg;
  typedef enum logic [1:0] {
    MFD_M_RETURN = 2'b00,
    MFD_M_SEQ1   = 2'b01,
    MFD_M_JUMP   = 2'b10,
    MFD_M_SEQ3   = 2'b11
  } mfd_mode_e;
  typedef enum logic [1:0] {
    MFD_FMT_1 = 2'b01,
    MFD_FMT_2 = 2'b10,
    MFD_FMT_3 = 2'b11
  } mfd_fmt_e;
  typedef logic [31:0] mfd_word_t;
endpackage

// [logic/mfd_apb_port.sv]
`timescale 1ns/1ps
module mfd_apb_port #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic              i_hit,
  output logic                   o_wr_en,
  output logic                   o_rd_en,
  output logic                   o_pready,
  output logic                   o_pslverr
);
  logic access;
  // zero wait states: every access completes in its first access cycle
  assign access    = i_psel & i_penable;
  assign o_pready  = 1'b1;
  assign o_wr_en   = access & i_pwrite & i_hit;
  assign o_rd_en   = access & ~i_pwrite & i_hit;
  assign o_pslverr = access & ~i_hit;
endmodule // mfd_apb_port

// [logic/mfd_decoder.sv]
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "mfd_cfg.svh"
module mfd_decoder import mfd_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  // current word and sequencer state
  input  wire logic [31:0]       i_uinstr,
  input  wire logic              i_exec,
  input  wire logic [11:0]       i_rtn_addr,
  input  wire logic [7:0]        i_mac,
  input  wire logic [3:0]        i_cur_page,
  // register bus
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // decoded controls, combinational from the current word
  output logic [1:0]             o_mode,
  output logic [1:0]             o_format,
  output logic                   o_subformat_select,
  output logic [4:0]             o_alu_func,
  output logic                   o_is_shift,
  output logic [2:0]             o_src_a,
  output logic [2:0]             o_src_b,
  output logic [2:0]             o_dest,
  output logic                   o_dest_en,
  output logic                   o_shift_right,
  output logic                   o_shift_left,
  output logic                   o_shift_aq,
  output logic [1:0]             o_shift_ctl,
  output logic [2:0]             o_test_code,
  output logic                   o_test_alt,
  output logic [3:0]             o_spec_code,
  output logic                   o_spec_valid,
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic                   o_alt_a,
  output logic                   o_alt_b,
  output logic                   o_alt_d,
  output logic [6:0]             o_const_code,
  output logic                   o_const_valid,
  output logic [6:0]             o_xform_code,
  output logic                   o_xform_valid,
  output logic [11:0]            o_next_addr,
  output logic                   o_n_load,
  output logic                   o_k_load,
  output logic [7:0]             o_nk_data
);
  mfd_mode_e   mode;
  logic        sf;
  logic [3:0]  spec;
  logic [7:0]  cfield;
  logic [6:0]  ccode;
  logic        fmt1;
  logic        fmt2;
  logic        fmt3;
  logic        xform_hit;
  logic        spec_ok;
  logic        hit;
  logic        wr_en;
  logic        rd_setup;
  logic        hi_zero;
  logic        wr_ctrl;
  logic        wr_xform;
  logic        spec_cmd;
  logic [7:0]  offs;
  logic        ovr_q;
  logic [6:0]  xval_q;
  logic [6:0]  xmsk_q;
  logic [7:0]  n_q;
  logic [7:0]  k_q;
  logic [31:0] last_ui_q;
  logic [11:0] last_next_q;
  logic [1:0]  last_mode_q;
  logic [31:0] exec_cnt_q;
  logic [31:0] rdata;
  logic [31:0] prdata_q;

  // field split, vector index equals bit number, bit 31 is the MSB
  assign mode   = mfd_mode_e'(i_uinstr[`MFD_MODE_LSB +: 2]); // see RULE1
  assign sf     = i_uinstr[`MFD_SF_BIT]; // see RULE4
  assign spec   = i_uinstr[`MFD_SPEC_LSB +: 4]; // see RULE2
  assign cfield = i_uinstr[`MFD_CONST_LSB +: 8]; // see RULE2
  assign ccode  = i_uinstr[`MFD_CCODE_LSB +: 7];
  assign o_mode = mode;

  always_comb begin // see RULE3
    fmt1 = 1'b0;
    fmt2 = 1'b0;
    fmt3 = 1'b0;
    case (mode)
      MFD_M_RETURN: fmt1 = 1'b1;
      MFD_M_SEQ1:   fmt1 = 1'b1;
      MFD_M_JUMP:   fmt2 = 1'b1;
      MFD_M_SEQ3:   fmt3 = 1'b1;
      default:      fmt1 = 1'b1;
    endcase
  end

  always_comb begin
    case (mode)
      MFD_M_JUMP: o_format = MFD_FMT_2;
      MFD_M_SEQ3: o_format = MFD_FMT_3;
      default:    o_format = MFD_FMT_1;
    endcase
  end

  // in format 3 bit 19 is the N/K select, not a subformat
  assign o_subformat_select = (fmt1 | fmt2) & sf; // see RULE4

  // ALU control; shift codes take the top F group
  assign o_alu_func = i_uinstr[`MFD_ALU_F_LSB +: 5]; // see RULE5
  assign o_is_shift = (o_alu_func[4:2] == `MFD_SHIFT_F_HI); // see RULE6
  assign o_src_a    = o_is_shift ? 3'h0 : i_uinstr[`MFD_SRC_A_LSB +: 3]; // see RULE5
  assign o_src_b    = o_is_shift ? 3'h0 : i_uinstr[`MFD_SRC_B_LSB +: 3]; // see RULE5
  assign o_dest     = i_uinstr[`MFD_DEST_LSB +: 3]; // see RULE5
  // dest holds a no-op code for shifts, so no write-back
  assign o_dest_en  = ~o_is_shift; // see RULE6

  // bit 10 is deliberately not decoded for shifts
  assign o_shift_right = o_is_shift & i_uinstr[`MFD_SH_RIGHT]; // see RULE6
  assign o_shift_left  = o_is_shift & i_uinstr[`MFD_SH_LEFT]; // see RULE6
  assign o_shift_aq    = o_is_shift & i_uinstr[`MFD_SH_AQ]; // see RULE6
  assign o_shift_ctl   = o_is_shift ? i_uinstr[`MFD_SH_CTL_LSB +: 2] : 2'h0; // see RULE6

  // the sequencer uses these to pick upper or lower of the next pair
  assign o_test_code = i_uinstr[`MFD_TEST_LSB +: 3]; // see RULE7
  assign o_test_alt  = fmt1 & i_uinstr[`MFD_TALT_BIT]; // see RULE8

  // format 1 constant field: C' when sf is 0, transform C'' when 1
  assign o_const_valid = fmt1 & ~sf; // see RULE9
  assign o_xform_valid = fmt1 & sf; // see RULE9
  assign o_const_code  = o_const_valid ? ccode : 7'h00; // see RULE9
  assign o_xform_code  = o_xform_valid ? ccode : 7'h00; // see RULE9

  // masked compare picks the transform codes that the flag silences
  // one value/mask pair: only codes of one masked class can be silenced
  assign xform_hit = o_xform_valid & ((ccode & xmsk_q) == (xval_q & xmsk_q));

  always_comb begin
    spec_ok = 1'b0;
    if (fmt1) begin
      spec_ok = ~(ovr_q & xform_hit); // see RULE13
    end else if (fmt2) begin
      spec_ok = ~sf; // see RULE10
    end else begin
      spec_ok = 1'b1; // see RULE12
    end
  end

  assign o_spec_valid = spec_ok;
  assign o_spec_code  = spec_ok ? spec : 4'h0;

  // memory and alternate codings exist only in formats 1 and 2
  assign spec_cmd = spec_ok & ~fmt3; // see RULE14
  assign o_mem_rd = spec_cmd & (spec == `MFD_S_MEM_RD); // see RULE14
  assign o_mem_wr = spec_cmd & (spec == `MFD_S_MEM_WR); // see RULE14
  assign o_alt_a  = spec_cmd & (spec == `MFD_S_ALT_A); // see RULE14
  assign o_alt_b  = spec_cmd & (spec == `MFD_S_ALT_B); // see RULE14
  assign o_alt_d  = spec_cmd & (spec == `MFD_S_ALT_D); // see RULE14

  // next pair address, page in the top nibble
  always_comb begin // see RULE17
    case (mode)
      MFD_M_RETURN: o_next_addr = i_rtn_addr; // see RULE15
      MFD_M_JUMP: begin
        if (sf) begin
          o_next_addr = {spec, cfield}; // see RULE11 RULE16
        end else begin
          o_next_addr = {i_cur_page, cfield}; // see RULE10 RULE16
        end
      end
      MFD_M_SEQ1: o_next_addr = {i_cur_page, i_mac}; // see RULE15
      MFD_M_SEQ3: o_next_addr = {i_cur_page, i_mac}; // see RULE15
      default:    o_next_addr = {i_cur_page, i_mac};
    endcase
  end

  // load strobes qualified by execution so a stalled word loads nothing
  assign o_n_load  = fmt3 & sf & i_exec; // see RULE12
  assign o_k_load  = fmt3 & ~sf & i_exec; // see RULE12
  assign o_nk_data = cfield; // see RULE12

  // software copies of N and K for debug reads
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      n_q <= 8'h00;
    end else if (o_n_load) begin
      n_q <= cfield;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      k_q <= 8'h00;
    end else if (o_k_load) begin
      k_q <= cfield;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      last_ui_q   <= 32'h00000000;
      last_next_q <= 12'h000;
      last_mode_q <= 2'h0;
    end else if (i_exec) begin
      last_ui_q   <= i_uinstr;
      last_next_q <= o_next_addr;
      last_mode_q <= mode;
    end
  end

  // wraps silently; meant only as a rough activity gauge
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      exec_cnt_q <= 32'h00000000;
    end else if (i_exec) begin
      exec_cnt_q <= exec_cnt_q + 32'h00000001;
    end
  end

  // register bus
  assign offs = i_paddr[7:0];

  // a set address bit above the map is a miss, so registers do not alias
  if (ADDR_W > 8) begin : g_addr_hi
    assign hi_zero = ~|i_paddr[ADDR_W-1:8];
  end else begin : g_addr_lo
    assign hi_zero = 1'b1;
  end

  always_comb begin
    hit = hi_zero;
    case (offs)
      `MFD_OFS_CTRL:   rdata = {31'h00000000, ovr_q};
      `MFD_OFS_XFORM:  rdata = {17'h00000, xmsk_q, 1'b0, xval_q};
      `MFD_OFS_NREG:   rdata = {24'h000000, n_q};
      `MFD_OFS_KREG:   rdata = {24'h000000, k_q};
      `MFD_OFS_LASTUI: rdata = last_ui_q;
      `MFD_OFS_STATUS: rdata = {18'h00000, last_mode_q, last_next_q};
      `MFD_OFS_EXECNT: rdata = exec_cnt_q;
      default: begin
        rdata = 32'h00000000;
        hit   = 1'b0;
      end
    endcase
  end

  mfd_apb_port #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_hit     (hit),
    .o_wr_en   (wr_en),
    .o_rd_en   (),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr)
  );

  // read word is latched at the end of setup so prdata comes from a flop
  // and still stands in the zero-wait access phase
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite & hit;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_q <= rdata;
    end else begin
      prdata_q <= 32'h00000000;
    end
  end

  assign o_prdata = prdata_q;

  assign wr_ctrl  = wr_en & (offs == `MFD_OFS_CTRL);
  assign wr_xform = wr_en & (offs == `MFD_OFS_XFORM);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ovr_q <= `MFD_RST_CTRL;
    end else if (wr_ctrl) begin
      ovr_q <= i_pwdata[`MFD_CTRL_OVR]; // see RULE13
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      xval_q <= `MFD_RST_XVAL;
      xmsk_q <= `MFD_RST_XMSK;
    end else if (wr_xform) begin
      xval_q <= i_pwdata[`MFD_XF_VAL_LSB +: 7];
      xmsk_q <= i_pwdata[`MFD_XF_MSK_LSB +: 7];
    end
  end
endmodule // mfd_decoder

// [test/mfd_decoder_properties.sv]
`timescale 1ns/1ps
module mfd_decoder_properties (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic [31:0] i_uinstr,
  input wire logic        i_exec,
  input wire logic [11:0] i_rtn_addr,
  input wire logic [7:0]  i_mac,
  input wire logic [3:0]  i_cur_page,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic [1:0]  o_format,
  input wire logic        o_subformat_select,
  input wire logic [4:0]  o_alu_func,
  input wire logic [2:0]  o_dest,
  input wire logic [2:0]  o_test_code,
  input wire logic [11:0] o_next_addr,
  input wire logic        o_n_load,
  input wire logic        o_k_load,
  input wire logic [7:0]  o_nk_data
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire logic [1:0] mode_w = i_uinstr[1:0];
  a_field_split: assert property (
    o_alu_func == i_uinstr[6:2] && o_dest == i_uinstr[15:13] && o_test_code == i_uinstr[18:16])
    else $error("field split wrong");
  a_format_pick: assert property (
    o_format == (mode_w[1] ? mode_w : 2'h1)) else $error("format wrong");
  a_subfmt_bit: assert property (
    o_subformat_select == (i_uinstr[19] && mode_w != 2'h3)) else $error("subformat wrong");
  a_return_addr: assert property (
    mode_w == 2'h0 |-> o_next_addr == i_rtn_addr) else $error("return address wrong");
  a_seq_addr: assert property (
    mode_w[0] |-> o_next_addr == {i_cur_page, i_mac}) else $error("sequential address wrong");
  a_jump_addr: assert property (
    mode_w == 2'h2 |-> o_next_addr == {(i_uinstr[19] ? i_uinstr[23:20] : i_cur_page),
    i_uinstr[31:24]}) else $error("jump address wrong");
  a_nk_select: assert property (
    mode_w == 2'h3 && i_exec |-> o_n_load == i_uinstr[19] && o_k_load == !i_uinstr[19]
    && o_nk_data == i_uinstr[31:24]) else $error("n k load wrong");
  a_no_load: assert property (
    !i_exec || mode_w != 2'h3 |-> !o_n_load && !o_k_load) else $error("stray n k load");
  a_hold_stable: assert property (
    $stable(i_uinstr) && $stable(i_mac) && $stable(i_rtn_addr) && $stable(i_cur_page)
    |-> $stable(o_next_addr) && $stable(o_format)) else $error("decode moved");
  a_zero_wait: assert property (
    i_psel && i_penable |-> o_pready) else $error("pready low");
endmodule // mfd_decoder_properties

bind mfd_decoder mfd_decoder_properties i_props (.i_mclk, .i_sys_rst, .i_uinstr, .i_exec,
  .i_rtn_addr, .i_mac, .i_cur_page, .i_psel, .i_penable, .o_pready, .o_format,
  .o_subformat_select, .o_alu_func, .o_dest, .o_test_code, .o_next_addr, .o_n_load,
  .o_k_load, .o_nk_data);

// [test/mfd_seq_model.sv]
`timescale 1ns/1ps
module mfd_seq_model #(
  parameter logic [11:0] RTN  = 12'hA5C,
  parameter logic [3:0]  PAGE = 4'h6
) (
  input  wire logic  i_mclk,
  input  wire logic  i_sys_rst,
  input  wire logic  i_exec,
  output logic [11:0] o_rtn_addr,
  output logic [7:0]  o_mac,
  output logic [3:0]  o_cur_page
);
  assign o_rtn_addr = RTN;
  assign o_cur_page = PAGE;
  // counter moves only on executed words, so a stalled word keeps its pair
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mac <= 8'h00;
    end else if (i_exec) begin
      o_mac <= o_mac + 8'h01;
    end
  end
endmodule // mfd_seq_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_exec = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00, i_mac, o_nk_data;
  logic [31:0] i_uinstr = 32'h0, i_pwdata = 32'h0, o_prdata, rd;
  logic [11:0] i_rtn_addr, o_next_addr, e;
  logic [3:0] i_cur_page, o_spec_code;
  logic [6:0] o_const_code, o_xform_code;
  logic [4:0] o_alu_func;
  logic [2:0] o_src_a, o_src_b, o_dest, o_test_code;
  logic [1:0] o_mode, o_format, o_shift_ctl;
  logic o_pready, o_pslverr, o_subformat_select, o_is_shift, o_dest_en, o_shift_right, er;
  logic o_shift_left, o_shift_aq, o_test_alt, o_spec_valid, o_mem_rd, o_mem_wr, o_alt_a;
  logic o_alt_b, o_alt_d, o_const_valid, o_xform_valid, o_n_load, o_k_load;
  int n_mismatch = 0, n_compared = 0;
  always #50 i_mclk = ~i_mclk;
  mfd_seq_model i_mfd_seq_model (.i_mclk, .i_sys_rst, .i_exec, .o_rtn_addr(i_rtn_addr),
    .o_mac(i_mac), .o_cur_page(i_cur_page));
  mfd_decoder i_mfd_decoder (.i_mclk, .i_sys_rst, .i_uinstr, .i_exec, .i_rtn_addr, .i_mac,
    .i_cur_page, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_mode, .o_format, .o_subformat_select, .o_alu_func, .o_is_shift, .o_src_a,
    .o_src_b, .o_dest, .o_dest_en, .o_shift_right, .o_shift_left, .o_shift_aq, .o_shift_ctl,
    .o_test_code, .o_test_alt, .o_spec_code, .o_spec_valid, .o_mem_rd, .o_mem_wr, .o_alt_a,
    .o_alt_b, .o_alt_d, .o_const_code, .o_const_valid, .o_xform_code, .o_xform_valid,
    .o_next_addr, .o_n_load, .o_k_load, .o_nk_data);
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // decode is combinational, so look a little after the launching edge
  task automatic put(input logic [31:0] w, input logic x);
    @(posedge i_mclk);
    i_uinstr <= w;
    i_exec <= x;
    #10;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_pready !== 1'b1 && k < 16);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic t_alu;
    put({13'h0000, 3'h4, 3'h6, 3'h5, 3'h3, 5'h18, 2'h1}, 1'b0);
    chk("alu", {5'h18, 3'h3, 3'h5, 3'h6, 2'h2, 3'h4}, {o_alu_func, o_src_a, o_src_b, o_dest,
      o_dest_en, o_is_shift, o_test_code});
    put({13'h0000, 3'h0, 3'h7, 2'h2, 1'h1, 1'h1, 1'h0, 1'h1, 5'h1C, 2'h1}, 1'b0);
    chk("shift", {5'h15, 2'h2, 6'h00}, {o_is_shift, o_dest_en, o_shift_right, o_shift_left,
      o_shift_aq, o_shift_ctl, o_src_a, o_src_b});
    $display("t_alu done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        put({8'hC3, 4'h9, s[0], 17'h00000, m[1:0]}, 1'b0);
        e = (m == 0) ? i_rtn_addr : (m == 2) ? {(s[0] ? 4'h9 : i_cur_page), 8'hC3}
          : {i_cur_page, i_mac};
        chk("next", e, o_next_addr);
        chk("fmt", {m[1:0], (m > 1) ? m[1:0] : 2'h1, s[0] && m != 3},
          {o_mode, o_format, o_subformat_select});
      end
    end
    $display("t_modes done");
  endtask
  task automatic t_special;
    for (int s = 1; s < 6; s++) begin
      put({7'h5A, 1'h1, s[3:0], 1'h0, 17'h00000, 2'h1}, 1'b0);
      chk("fmt1 c", {5'h10 >> (s - 1), 1'h1, 7'h5A, 7'h00, s[3:0], 2'h2}, {o_mem_rd, o_mem_wr,
        o_alt_a, o_alt_b, o_alt_d, o_test_alt, o_const_code, o_xform_code, o_spec_code,
        o_const_valid, o_xform_valid});
    end
    put({7'h5A, 1'h0, 4'h1, 1'h1, 17'h00000, 2'h1}, 1'b0);
    chk("fmt1 x", {1'h0, 7'h00, 7'h5A, 1'h1, 4'h1, 2'h1}, {o_test_alt, o_const_code,
      o_xform_code, o_mem_rd, o_spec_code, o_const_valid, o_xform_valid});
    put({8'h00, 4'h2, 1'h0, 17'h00000, 2'h2}, 1'b0);
    chk("fmt2 s0", 2'h3, {o_spec_valid, o_mem_wr});
    put({8'h00, 4'h2, 1'h1, 17'h00000, 2'h2}, 1'b0);
    chk("fmt2 s1", 6'h00, {o_spec_valid, o_mem_wr, o_spec_code});
    $display("t_special done");
  endtask
  task automatic t_nk;
    put({8'h3C, 4'h5, 1'h1, 17'h00000, 2'h3}, 1'b1);
    chk("n load", {2'h2, 8'h3C, 1'h1, 4'h5, 1'h0}, {o_n_load, o_k_load, o_nk_data,
      o_spec_valid, o_spec_code, o_alt_d});
    put({8'hA7, 4'h0, 1'h0, 17'h00000, 2'h3}, 1'b1);
    chk("k load", {2'h1, 8'hA7}, {o_n_load, o_k_load, o_nk_data});
    put(32'h0000_0003, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk("n reg", 32'h0000_003C, rd);
    chk("n reg err", 32'h0000_0000, {31'h0, er});
    apb(1'b0, 8'h0C, 32'h0);
    chk("k reg", 32'h0000_00A7, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("last word", 32'hA700_0003, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("status", 32'h0000_3601, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("exec count", 32'h0000_0002, rd);
    $display("t_nk done");
  endtask
  task automatic t_ovr;
    apb(1'b0, 8'h04, 32'h0);
    chk("xform rst", 32'h0000_7F00, rd);
    apb(1'b1, 8'h04, 32'h0000_7F12);
    apb(1'b1, 8'h00, 32'h0000_0001);
    put({7'h12, 1'h0, 4'h1, 1'h1, 17'h00000, 2'h1}, 1'b0);
    chk("suppress", 6'h00, {o_spec_valid, o_mem_rd, o_spec_code});
    put({7'h13, 1'h0, 4'h1, 1'h1, 17'h00000, 2'h1}, 1'b0);
    chk("no match", 6'h31, {o_spec_valid, o_mem_rd, o_spec_code});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("t_ovr done");
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_alu();
    t_modes();
    t_special();
    t_nk();
    t_ovr();
    wrap_up();
  end
endmodule // testbench
